// file: src/dual_uart_host_bus_port.sv
// Strobe-driven parallel host port of a two-channel serial controller.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dual_uart_host_bus_port (
    // Clock and reset.
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    // Host bus pins.
    input  wire logic                              cs_n_i,
    input  wire logic                              read_strobe_n_i,
    input  wire logic                              write_strobe_n_i,
    input  wire logic                              channel_pick_i,
    input  wire logic                              reg_addr_bit2_i,
    input  wire logic                              reg_addr_bit1_i,
    input  wire logic                              reg_addr_bit0_i,
    input  wire logic [host_port_pkg::DATA_W-1:0]  data_i,
    output logic      [host_port_pkg::DATA_W-1:0]  data_o,
    output logic                                   data_oe_o,
    // Register access towards the two channels.
    input  wire logic [host_port_pkg::DATA_W-1:0]  alternate_function_config_i,
    output logic      [host_port_pkg::ADDR_W-1:0]  reg_addr_o,
    output logic      [host_port_pkg::DATA_W-1:0]  wr_data_o,
    output logic                                   wr_chan_a_o,
    output logic                                   wr_chan_b_o,
    output logic                                   rd_chan_a_o,
    output logic                                   rd_chan_b_o,
    input  wire logic [host_port_pkg::DATA_W-1:0]  rd_data_a_i,
    input  wire logic [host_port_pkg::DATA_W-1:0]  rd_data_b_i,
    // Channel status in and status pins out.
    input  wire logic                              irq_req_a_i,
    input  wire logic                              irq_req_b_i,
    input  wire logic                              tx_ready_a_i,
    input  wire logic                              tx_ready_b_i,
    output logic                                   irq_chan_a_o,
    output logic                                   irq_chan_b_o,
    output logic                                   tx_ready_chan_a_n_o,
    output logic                                   tx_ready_chan_b_n_o
);

    typedef struct packed {
        logic                               rd_prev;
        logic                               wr_prev;
        host_port_pkg::phase_type           phase;
        logic                               read_a;
        logic                               write_a;
        logic [host_port_pkg::ADDR_W-1:0]   addr;
        logic [host_port_pkg::DATA_W-1:0]   wdata;
        logic [host_port_pkg::DATA_W-1:0]   rdata;
        logic                               oe;
        logic                               wr_a;
        logic                               wr_b;
        logic                               rd_a;
        logic                               rd_b;
        logic                               irq_a;
        logic                               irq_b;
        logic                               txr_a_n;
        logic                               txr_b_n;
    } state_type;

    localparam state_type STATE_RESET = '{
        rd_prev: 1'b1,
        wr_prev: 1'b1,
        phase:   host_port_pkg::PHASE_IDLE,
        read_a:  1'b0,
        write_a: 1'b0,
        addr:    3'h0,
        wdata:   host_port_pkg::DATA_RESET,
        rdata:   host_port_pkg::DATA_RESET,
        oe:      1'b0,
        wr_a:    1'b0,
        wr_b:    1'b0,
        rd_a:    1'b0,
        rd_b:    1'b0,
        irq_a:   1'b0,
        irq_b:   1'b0,
        txr_a_n: 1'b1,
        txr_b_n: 1'b1
    };

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    logic [host_port_pkg::PIN_ALL_W-1:0] pins_raw;
    logic [host_port_pkg::PIN_ALL_W-1:0] pins_f;
    logic                                cs_f;
    logic                                rd_f;
    logic                                wr_f;
    logic                                pick_f;
    logic [host_port_pkg::ADDR_W-1:0]    addr_f;
    logic [host_port_pkg::DATA_W-1:0]    data_f;
    logic                                rd_fall;
    logic                                wr_fall;
    logic                                wr_rise;
    logic                                broadcast;

    state_type st_reg;
    state_type st_next;

    // Address and data are filtered with the strobes, so they keep the same
    // timing relation to them that the host gave on the pins.
    assign pins_raw = {cs_n_i, read_strobe_n_i, write_strobe_n_i,
                       channel_pick_i, reg_addr_bit2_i, reg_addr_bit1_i,
                       reg_addr_bit0_i, data_i};

    pin_filter u_pin_filter (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pin_i   (pins_raw),
        .level_o (pins_f)
    );

    assign cs_f   = pins_f[host_port_pkg::PIN_CS];
    assign rd_f   = pins_f[host_port_pkg::PIN_RD];
    assign wr_f   = pins_f[host_port_pkg::PIN_WR];
    assign pick_f = pins_f[host_port_pkg::PIN_CHANNEL_PICK];
    assign addr_f = pins_f[host_port_pkg::PIN_ADDR +: host_port_pkg::ADDR_W];
    assign data_f = pins_f[host_port_pkg::PIN_DATA +: host_port_pkg::DATA_W];

    assign rd_fall   = st_reg.rd_prev & ~rd_f;
    assign wr_fall   = st_reg.wr_prev & ~wr_f;
    assign wr_rise   = ~st_reg.wr_prev & wr_f;
    assign broadcast =
        alternate_function_config_i[host_port_pkg::AFC_BROADCAST];

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencing.

    always_comb begin
        st_next         = st_reg;
        st_next.rd_prev = rd_f;
        st_next.wr_prev = wr_f;
        st_next.wr_a    = 1'b0;
        st_next.wr_b    = 1'b0;
        st_next.rd_a    = 1'b0;
        st_next.rd_b    = 1'b0;
        // The bus is driven only inside a selected read, never otherwise.
        st_next.oe      = ~cs_f & ~rd_f;

        case (st_reg.phase)
            host_port_pkg::PHASE_IDLE: begin
                if (rd_fall && !cs_f) begin
                    st_next.read_a = pick_f;
                    st_next.addr   = addr_f;
                    st_next.rd_a   = pick_f;
                    st_next.rd_b   = ~pick_f;
                    st_next.phase  = host_port_pkg::PHASE_FETCH;
                end
            end
            host_port_pkg::PHASE_FETCH: begin
                // The channel answers in the same cycle as the read pulse; the
                // byte then stays put so the host can take it at its rising
                // strobe however late that comes.
                st_next.rdata = st_reg.read_a ? rd_data_a_i
                                              : rd_data_b_i;
                st_next.phase = host_port_pkg::PHASE_IDLE;
            end
            default: begin
                st_next.phase = host_port_pkg::PHASE_IDLE;
            end
        endcase

        if (wr_fall && !cs_f) begin
            st_next.write_a = pick_f;
        end
        if (wr_rise && !cs_f) begin
            st_next.addr  = addr_f;
            st_next.wdata = data_f;
            st_next.wr_a  = broadcast | st_reg.write_a;
            st_next.wr_b  = broadcast | ~st_reg.write_a;
        end

        st_next.irq_a   = irq_req_a_i;
        st_next.irq_b   = irq_req_b_i;
        st_next.txr_a_n = ~tx_ready_a_i;
        st_next.txr_b_n = ~tx_ready_b_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign data_o              = st_reg.rdata;
    assign data_oe_o           = st_reg.oe;
    assign reg_addr_o          = st_reg.addr;
    assign wr_data_o           = st_reg.wdata;
    assign wr_chan_a_o         = st_reg.wr_a;
    assign wr_chan_b_o         = st_reg.wr_b;
    assign rd_chan_a_o         = st_reg.rd_a;
    assign rd_chan_b_o         = st_reg.rd_b;
    assign irq_chan_a_o        = st_reg.irq_a;
    assign irq_chan_b_o        = st_reg.irq_b;
    assign tx_ready_chan_a_n_o = st_reg.txr_a_n;
    assign tx_ready_chan_b_n_o = st_reg.txr_b_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence read_start;
        rd_fall && !cs_f;
    endsequence

    sequence write_end;
        wr_rise && !cs_f;
    endsequence

    read_start_a: assert property (
        read_start |=> (rd_chan_a_o ^ rd_chan_b_o)
            ##1 (data_o == $past(rd_chan_a_o ? rd_data_a_i : rd_data_b_i)))
        else $error("read did not fetch and hold the channel byte");

    read_pick_a: assert property (
        read_start |=> (rd_chan_a_o == $past(pick_f))
                    && (rd_chan_b_o == !$past(pick_f)))
        else $error("read went to the wrong channel");

    read_addr_a: assert property (
        read_start |=> reg_addr_o == $past(addr_f))
        else $error("read address not taken from the address lines");

    write_load_a: assert property (
        write_end |=> (wr_chan_a_o || wr_chan_b_o)
                   && (wr_data_o == $past(data_f)))
        else $error("write did not load the bus byte");

    write_both_a: assert property (
        write_end and broadcast |=> wr_chan_a_o && wr_chan_b_o)
        else $error("broadcast write missed a channel");

    write_single_a: assert property (
        write_end and !broadcast |=> wr_chan_a_o != wr_chan_b_o)
        else $error("single write reached both or no channel");

    deselect_quiet_a: assert property (
        cs_f |=> !(wr_chan_a_o || wr_chan_b_o || rd_chan_a_o || rd_chan_b_o))
        else $error("access made without chip select");

    drive_window_a: assert property (
        data_oe_o == $past(!cs_f && !rd_f))
        else $error("data bus driven outside a selected read");

    status_follow_a: assert property (
        $past(rst_b_i) |-> irq_chan_a_o == $past(irq_req_a_i)
            && irq_chan_b_o == $past(irq_req_b_i)
            && tx_ready_chan_a_n_o == !$past(tx_ready_a_i)
            && tx_ready_chan_b_n_o == !$past(tx_ready_b_i))
        else $error("status pin does not follow its channel");

endmodule : dual_uart_host_bus_port

`default_nettype wire

// file: src/host_port_pkg.sv
// Constants shared by the parallel host port and its pin filter.
`default_nettype none

package host_port_pkg;

    // Widths of the host bus.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Layout of the synchronised pin vector.
    localparam int PIN_W     = 14;
    localparam int PIN_DATA  = 0;
    localparam int PIN_ADDR  = 8;
    localparam int PIN_CHANNEL_PICK = 11;
    localparam int PIN_WR    = 12;
    localparam int PIN_RD    = 13;
    localparam int PIN_CS    = 14;
    localparam int PIN_ALL_W = 15;

    // Idle pin levels: chip select and both strobes high, the rest low.
    localparam logic [PIN_ALL_W-1:0] PIN_IDLE = 15'h7000;

    // Bit of the alternate function configuration that merges channels.
    localparam int AFC_BROADCAST = 0;

    // Reset values of the host-facing outputs.
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // Read sequencing phases.
    typedef enum logic [0:0] {
        PHASE_IDLE,
        PHASE_FETCH
    } phase_type;

endpackage : host_port_pkg

`default_nettype wire

// file: src/pin_filter.sv
// Three-stage synchroniser that accepts a pin change once stages agree.
`default_nettype none

module pin_filter (
    // Clock and reset.
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_b_i,
    // Raw pins and their accepted levels.
    input  wire logic [host_port_pkg::PIN_ALL_W-1:0]  pin_i,
    output logic      [host_port_pkg::PIN_ALL_W-1:0]  level_o
);

    typedef struct packed {
        logic [host_port_pkg::PIN_ALL_W-1:0] s1;
        logic [host_port_pkg::PIN_ALL_W-1:0] s2;
        logic [host_port_pkg::PIN_ALL_W-1:0] s3;
        logic [host_port_pkg::PIN_ALL_W-1:0] level;
    } filter_type;

    filter_type st_reg;
    filter_type st_next;

    // The first stage feeds only the second; the level only moves on bits
    // where the second and third stages hold the same value.
    always_comb begin
        st_next       = st_reg;
        st_next.s1    = pin_i;
        st_next.s2    = st_reg.s1;
        st_next.s3    = st_reg.s2;
        st_next.level = (st_reg.s2 & ~(st_reg.s2 ^ st_reg.s3))
                      | (st_reg.level & (st_reg.s2 ^ st_reg.s3));
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_reg <= {4{host_port_pkg::PIN_IDLE}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_o = st_reg.level;

endmodule : pin_filter

`default_nettype wire

// file: verif/dual_uart_host_bus_port_test.sv
// Self-checking bench for the parallel host port.
`default_nettype none

module dual_uart_host_bus_port_test;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic       wr;
        logic       pick;
        logic [7:0] afc;
        logic [2:0] addr;
        logic [7:0] wd;
        logic [3:0] exp;
    } row_type;

    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       cs_n, rd_n, wr_n, pick, host_oe;
    logic [2:0] addr;
    logic [7:0] host_data, bus, data_o, afc = 8'h00, wr_data_o, got;
    logic [7:0] rd_data_a_i, rd_data_b_i, last_wd, last_addr;
    logic       data_oe_o, wr_chan_a_o, wr_chan_b_o, rd_chan_a_o, rd_chan_b_o;
    logic       irq_chan_a_o, irq_chan_b_o;
    logic       tx_ready_chan_a_n_o, tx_ready_chan_b_n_o;
    logic [3:0] stat = 4'h0;
    logic [2:0] reg_addr_o;
    int         errors = 0;
    int         check_count = 0;
    int         cycles = 0;
    int         clash = 0;
    int         cnt[5] = '{0, 0, 0, 0, 0};
    int         base[5];
    row_type    rows[8] = '{
        '{1'b1, 1'b1, 8'h00, 3'h7, 8'ha5, 4'h8},
        '{1'b1, 1'b0, 8'hfe, 3'h0, 8'h3c, 4'h4},
        '{1'b1, 1'b0, 8'h01, 3'h3, 8'h81, 4'hc},
        '{1'b1, 1'b1, 8'hff, 3'h6, 8'h7e, 4'hc},
        '{1'b0, 1'b1, 8'h00, 3'h5, 8'h00, 4'h2},
        '{1'b0, 1'b0, 8'h00, 3'h2, 8'h00, 4'h1},
        '{1'b0, 1'b1, 8'h01, 3'h7, 8'h00, 4'h2},
        '{1'b0, 1'b0, 8'h01, 3'h0, 8'h00, 4'h1}};

    always #20 clk_i = ~clk_i;
    assign bus = data_oe_o ? data_o : host_data;
    // Each channel answers with its own tag and the address it was given.
    assign rd_data_a_i = {5'h1a, reg_addr_o};
    assign rd_data_b_i = {5'h0c, reg_addr_o};

    host_model host_model_i (.clk_i, .cs_n_o(cs_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .pick_o(pick), .addr_o(addr), .data_o(host_data),
        .oe_o(host_oe), .bus_i(bus));

    dual_uart_host_bus_port dual_uart_host_bus_port_i (.clk_i, .rst_b_i,
        .cs_n_i(cs_n), .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n),
        .channel_pick_i(pick), .reg_addr_bit2_i(addr[2]),
        .reg_addr_bit1_i(addr[1]), .reg_addr_bit0_i(addr[0]), .data_i(bus),
        .data_o, .data_oe_o, .alternate_function_config_i(afc), .reg_addr_o,
        .wr_data_o, .wr_chan_a_o, .wr_chan_b_o, .rd_chan_a_o, .rd_chan_b_o,
        .rd_data_a_i, .rd_data_b_i, .irq_req_a_i(stat[3]),
        .irq_req_b_i(stat[2]), .tx_ready_a_i(stat[1]),
        .tx_ready_b_i(stat[0]), .irq_chan_a_o, .irq_chan_b_o,
        .tx_ready_chan_a_n_o, .tx_ready_chan_b_n_o);

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    // Pulse and drive counters, so no single-cycle event is missed.
    always @(posedge clk_i) begin
        cnt[0] += int'(wr_chan_a_o === 1'b1);
        cnt[1] += int'(wr_chan_b_o === 1'b1);
        cnt[2] += int'(rd_chan_a_o === 1'b1);
        cnt[3] += int'(rd_chan_b_o === 1'b1);
        cnt[4] += int'(data_oe_o === 1'b1);
        // Both ends driving the wire at once would corrupt the byte.
        clash += int'(host_oe === 1'b1 && data_oe_o === 1'b1);
        if (wr_chan_a_o === 1'b1 || wr_chan_b_o === 1'b1) begin
            last_wd = wr_data_o;
            last_addr = {5'h00, reg_addr_o};
        end
        cycles++;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_i);
        check("reset_oe", {7'h00, data_oe_o}, 8'h00);
        check("reset_irq", {6'h00, irq_chan_a_o, irq_chan_b_o},
              8'h00);
        check("reset_txr", {6'h00, tx_ready_chan_a_n_o,
              tx_ready_chan_b_n_o}, 8'h03);
        rst_b_i = 1'b1;
        foreach (rows[i]) begin
            afc = rows[i].afc;
            base = cnt;
            host_model_i.xfer(1'b1, rows[i].wr, rows[i].pick, rows[i].addr,
                              rows[i].wd, got);
            for (int k = 0; k < 4; k++) begin
                check($sformatf("pulse%0d", k), 8'(cnt[k] - base[k]),
                      {7'h00, rows[i].exp[3-k]});
            end
            if (rows[i].wr) begin
                check("wr_data", last_wd, rows[i].wd);
                check("wr_addr", last_addr, {5'h00, rows[i].addr});
                check("wr_oe", 8'(cnt[4] - base[4]), 8'h00);
            end else begin
                check("rd_byte", got, {rows[i].pick ? 5'h1a : 5'h0c,
                      rows[i].addr});
                check("rd_oe", 8'(cnt[4] > base[4]), 8'h01);
            end
        end
        // Strobes without chip select must leave the port untouched.
        for (int w = 0; w < 2; w++) begin
            base = cnt;
            host_model_i.xfer(1'b0, w[0], 1'b1, 3'h4, 8'h99, got);
            for (int k = 0; k < 5; k++) begin
                check("no_cs", 8'(cnt[k] - base[k]), 8'h00);
            end
        end
        for (int p = 0; p < 2; p++) begin
            @(negedge clk_i);
            stat = p[0] ? 4'h6 : 4'h9;
            repeat (2) @(negedge clk_i);
            check("irq_a", {7'h00, irq_chan_a_o}, {7'h00, stat[3]});
            check("irq_b", {7'h00, irq_chan_b_o}, {7'h00, stat[2]});
            check("txr_a", {7'h00, tx_ready_chan_a_n_o},
                  {7'h00, ~stat[1]});
            check("txr_b", {7'h00, tx_ready_chan_b_n_o},
                  {7'h00, ~stat[0]});
        end
        // A reset in mid-run must bring the data, drive and status outputs back to idle within two cycles.
        @(negedge clk_i);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("mid_rst_data", data_o, 8'h00);
        check("mid_rst_wd", wr_data_o, 8'h00);
        check("mid_rst_oe", {7'h00, data_oe_o}, 8'h00);
        check("mid_rst_irq", {6'h00, irq_chan_a_o, irq_chan_b_o},
              8'h00);
        check("mid_rst_txr", {6'h00, tx_ready_chan_a_n_o,
              tx_ready_chan_b_n_o}, 8'h03);
        rst_b_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check("rel_irq_b", {7'h00, irq_chan_b_o}, 8'h01);
        check("rel_txr_a", {7'h00, tx_ready_chan_a_n_o}, 8'h00);
        // The first read after the release must still reach its channel.
        base = cnt;
        host_model_i.xfer(1'b1, 1'b0, 1'b1, 3'h5, 8'h00, got);
        check("rel_rd", got, 8'hd5);
        check("rel_pulse", 8'(cnt[2] - base[2]), 8'h01);
        check("clash", 8'(clash), 8'h00);
        give_verdict();
    end

endmodule : dual_uart_host_bus_port_test

`default_nettype wire

// file: verif/host_model.sv
// Host processor model that runs strobe cycles on the parallel port.
`default_nettype none

module host_model (
    // Clock.
    input  wire logic       clk_i,
    // Bus pins driven towards the port.
    output logic            cs_n_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic            pick_o,
    output logic [2:0]      addr_o,
    output logic [7:0]      data_o,
    output logic            oe_o,
    // Resolved data wire.
    input  wire logic [7:0] bus_i
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        pick_o = 1'b0;
        addr_o = 3'h0;
        data_o = 8'h5a;
        oe_o   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobes last eight cycles and qualifiers stand well around each edge,
    // because the port only sees pin levels through its synchroniser.
    task automatic xfer(input logic cs_on, input logic wr, input logic pick,
                        input logic [2:0] addr, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(negedge clk_i);
        pick_o = pick;
        addr_o = addr;
        data_o = wd;
        oe_o   = wr;
        repeat (5) @(negedge clk_i);
        cs_n_o = !cs_on;
        if (wr) begin
            wr_n_o = 1'b0;
        end else begin
            rd_n_o = 1'b0;
        end
        repeat (8) @(negedge clk_i);
        rd = bus_i;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        repeat (6) @(negedge clk_i);
        cs_n_o = 1'b1;
        oe_o   = 1'b0;
        // A released wire must not keep showing the old byte.
        data_o = ~wd;
        addr_o = ~addr;
        pick_o = ~pick;
        repeat (5) @(negedge clk_i);
    endtask : xfer

endmodule : host_model

`default_nettype wire
